// ==== rtl/tandem_connection_monitor_sink.v ====
/*
 Non-intrusive tandem connection sink monitor for VC-11 with an APB
 register slave. Assumes the VC-11 byte stream, frame start, N2 strobe,
 server fail, equipment defect and one-second tick all come from logic
 on core_clk_in.
*/
// Decided for this implementation: the register addresses and register access over APB.
// Function
// - Outgoing defect bit zero means normal
// - Align multiframe on N2 bits 7 and 8
// - Search for fifteen ones then a zero
// - Keep checking alignment at presumed position
// - Two errored alignment words enter out-of-multiframe
// - One clean alignment word enters in-multiframe
// - Five all-zero N2 bytes raise unequipped
// - Five non-zero N2 bytes clear unequipped
// - Connection loss follows out-of-multiframe state
// - Trace mismatch found and cleared within one second
// - Server fail suppresses trace mismatch
// - Control input disables trace mismatch detection
// - Degrade derived from BIP-2 violation counts
// - Remote defect from extracted remote indication
// - Outgoing defect from extracted outgoing indication
// - Trail fail and degrade from defects
// - Report unequipped; loss only when equipped
// - Report mismatch only without unequipped or loss
// - Report degrade only without mismatch or loss
// - Report server fail when enabled
// - Report remote defect when enabled, masked
// - Report outgoing defect when enabled, masked
// - Per-second defect seconds and block counts
// - Even BIP-2 over previous frame bytes
// - Remote defect bit one means defect
// - Outgoing defect bit one means defect
// - Accepted trace identifier readable by management
`timescale 1ns/10ps
`include "tcm_sink_regs.vh"

module tandem_connection_monitor_sink #(
  parameter EBC_W = 16
) (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output reg         pslverr_out,
  // VC-11 stream
  input  wire [7:0]  vc_byte_in,
  input  wire        vc_valid_in,
  input  wire        vc_frame_start_in,
  input  wire        vc_n2_in,
  input  wire        incoming_server_fail_in,
  input  wire        equipment_defect_in,
  input  wire        one_second_in,
  // Consequent actions
  output reg         trail_signal_fail_out,
  output reg         trail_signal_degrade_out,
  output reg         pm_update_out
);

////////////////////////////////////////////////////////////////////////
// Reset release
reg rst_meta;
reg rst_sync_n;

always @(posedge core_clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    rst_meta   <= 1'b0;
    rst_sync_n <= 1'b0;
  end else begin
    rst_meta   <= 1'b1;
    rst_sync_n <= rst_meta;
  end
end

////////////////////////////////////////////////////////////////////////
// BIP-2 over the preceding frame
wire       n2_hit   = vc_valid_in & vc_n2_in;
wire [1:0] byte_bip = vc_byte_in[7:6] ^ vc_byte_in[5:4] ^ vc_byte_in[3:2] ^ vc_byte_in[1:0];
reg  [1:0] bip_acc;
reg  [1:0] bip_prev;
reg        seen_frame;
reg        bip_prev_ok;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    bip_acc     <= 2'h0;
    bip_prev    <= 2'h0;
    seen_frame  <= 1'b0;
    bip_prev_ok <= 1'b0;
  end else if (vc_valid_in) begin
    if (vc_frame_start_in) begin
      bip_prev    <= bip_acc;
      bip_prev_ok <= seen_frame;
      seen_frame  <= 1'b1;
      bip_acc     <= byte_bip;
    end else begin
      bip_acc <= bip_acc ^ byte_bip;
    end
  end
end

// First frame after reset has no parity to compare against
wire near_errored_block = n2_hit & bip_prev_ok & (vc_byte_in[7:6] != bip_prev);
wire far_block          = n2_hit & vc_byte_in[3];
wire out_block          = n2_hit & vc_byte_in[2];

////////////////////////////////////////////////////////////////////////
// Multiframe alignment
localparam OUT_OF_MF = 1'b0;
localparam IN_MF     = 1'b1;

reg  [15:0] fas_shift;
wire [15:0] next_fas = {fas_shift[13:0], vc_byte_in[1], vc_byte_in[0]};
reg  [6:0]  mf_pos;
reg         mf_state;
reg         fas_err_prev;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    fas_shift    <= 16'h0000;
    mf_pos       <= 7'h00;
    mf_state     <= OUT_OF_MF;
    fas_err_prev <= 1'b0;
  end else if (n2_hit) begin
    fas_shift <= next_fas;
    case (mf_state)
      OUT_OF_MF: begin
        if (next_fas == `TCM_FAS) begin
          mf_state     <= IN_MF;
          mf_pos       <= `TCM_TTI_FIRST;
          fas_err_prev <= 1'b0;
        end
      end
      IN_MF: begin
        mf_pos <= (mf_pos == `TCM_MF_LAST) ? 7'h00 : mf_pos + 7'h01;
        if (mf_pos == `TCM_FAS_LAST) begin
          if (next_fas != `TCM_FAS) begin
            fas_err_prev <= 1'b1;
            if (fas_err_prev)
              mf_state <= OUT_OF_MF;
          end else begin
            fas_err_prev <= 1'b0;
          end
        end
      end
      default: mf_state <= OUT_OF_MF;
    endcase
  end
end

wire in_mf          = (mf_state == IN_MF);
wire tc_loss_defect = ~in_mf;

////////////////////////////////////////////////////////////////////////
// Trace, remote and outgoing indications
reg [127:0] tti_shift;
reg [127:0] last_rx_ti;
reg [127:0] accepted_trace_id;
reg         acc_valid;
reg         rdi_bit;
reg         odi_bit;

wire [127:0] next_tti = {tti_shift[125:0], vc_byte_in[1], vc_byte_in[0]};

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    tti_shift         <= 128'h0;
    last_rx_ti        <= 128'h0;
    accepted_trace_id <= 128'h0;
    acc_valid         <= 1'b0;
    rdi_bit           <= 1'b0;
    odi_bit           <= 1'b0;
  end else if (n2_hit && in_mf) begin
    if (mf_pos >= `TCM_TTI_FIRST && mf_pos <= `TCM_TTI_LAST)
      tti_shift <= next_tti;
    // Two identical multiframes in a row stand in for acceptance
    if (mf_pos == `TCM_TTI_LAST) begin
      last_rx_ti <= next_tti;
      if (next_tti == last_rx_ti) begin
        accepted_trace_id <= next_tti;
        acc_valid         <= 1'b1;
      end
    end
    if (mf_pos == `TCM_RDI_IDX)
      rdi_bit <= vc_byte_in[0];
    if (mf_pos == `TCM_ODI_IDX)
      odi_bit <= vc_byte_in[1];
  end
end

wire remote_defect   = in_mf & rdi_bit;
wire outgoing_defect = in_mf & odi_bit;

////////////////////////////////////////////////////////////////////////
// Unequipped persistence
reg [2:0] zero_run;
reg [2:0] nz_run;
reg       tc_unequipped_defect;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    zero_run             <= 3'h0;
    nz_run               <= 3'h0;
    tc_unequipped_defect <= 1'b0;
  end else if (n2_hit) begin
    if (vc_byte_in == 8'h00) begin
      nz_run <= 3'h0;
      if (zero_run != `TCM_UNEQ_N)
        zero_run <= zero_run + 3'h1;
      if (zero_run == `TCM_UNEQ_N - 3'h1)
        tc_unequipped_defect <= 1'b1;
    end else begin
      zero_run <= 3'h0;
      if (nz_run != `TCM_UNEQ_N)
        nz_run <= nz_run + 3'h1;
      if (nz_run == `TCM_UNEQ_N - 3'h1)
        tc_unequipped_defect <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Registers written by software
reg [`TCM_CTRL_W-1:0]    ctrl;
reg [`TCM_DEG_THR_W-1:0] deg_thr;
reg [`TCM_DEG_M_W-1:0]   deg_m;
reg [127:0]              exp_ti;

wire       termination_point_mode        = ctrl[`TCM_CTRL_MON];
wire       server_fail_report_enable     = ctrl[`TCM_CTRL_SSF_REP];
wire       remote_defect_report_enable   = ctrl[`TCM_CTRL_RDI_REP];
wire       outgoing_defect_report_enable = ctrl[`TCM_CTRL_ODI_REP];
wire       trace_mismatch_disable        = ctrl[`TCM_CTRL_TIM_DIS];
wire [1:0] widx                          = paddr_in[3:2];
wire       wr_en = psel_in & penable_in & pwrite_in;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    ctrl    <= `TCM_CTRL_RST;
    deg_thr <= `TCM_DEG_THR_RST;
    deg_m   <= `TCM_DEG_M_RST;
    exp_ti  <= 128'h0;
  end else if (wr_en) begin
    if (paddr_in == `TCM_CTRL)
      ctrl <= pwdata_in[`TCM_CTRL_W-1:0];
    if (paddr_in == `TCM_DEG_CFG) begin
      deg_thr <= pwdata_in[`TCM_DEG_THR_W-1:0];
      deg_m   <= pwdata_in[`TCM_DEG_M_LSB +: `TCM_DEG_M_W];
    end
    if (paddr_in[7:4] == `TCM_EXP_TI_HI)
      exp_ti[{~widx, 5'h1f} -: 32] <= pwdata_in;
  end
end

////////////////////////////////////////////////////////////////////////
// Mismatch, consequent actions and correlations
// Acceptance repeats every multiframe, far inside one second
wire trace_mismatch_defect = acc_valid & (accepted_trace_id != exp_ti)
                           & ~incoming_server_fail_in
                           & ~trace_mismatch_disable;
reg  signal_degrade_defect;
wire monitoring_active = termination_point_mode;
wire trail_signal_fail = incoming_server_fail_in | tc_unequipped_defect
                       | trace_mismatch_defect | tc_loss_defect;
wire masked_far = ~tc_unequipped_defect & ~trace_mismatch_defect & ~tc_loss_defect;
wire [6:0] next_reports;

assign next_reports[0] = monitoring_active & tc_unequipped_defect;
assign next_reports[1] = monitoring_active & ~tc_unequipped_defect & tc_loss_defect;
assign next_reports[2] = monitoring_active & ~tc_unequipped_defect & ~tc_loss_defect
                       & trace_mismatch_defect;
assign next_reports[3] = monitoring_active & ~trace_mismatch_defect & ~tc_loss_defect
                       & signal_degrade_defect;
assign next_reports[4] = monitoring_active & incoming_server_fail_in
                       & server_fail_report_enable;
assign next_reports[5] = monitoring_active & masked_far & remote_defect
                       & remote_defect_report_enable;
assign next_reports[6] = monitoring_active & masked_far & outgoing_defect
                       & outgoing_defect_report_enable;

reg [6:0] reports;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    reports                  <= 7'h00;
    trail_signal_fail_out    <= 1'b0;
    trail_signal_degrade_out <= 1'b0;
  end else begin
    reports                  <= next_reports;
    trail_signal_fail_out    <= trail_signal_fail;
    trail_signal_degrade_out <= signal_degrade_defect;
  end
end

////////////////////////////////////////////////////////////////////////
// One-second performance monitoring and degrade
function [EBC_W-1:0] sat_inc;
  input [EBC_W-1:0] acc;
  input             inc;
  begin
    sat_inc = (inc && acc != {EBC_W{1'b1}}) ? acc + {{(EBC_W-1){1'b0}}, 1'b1} : acc;
  end
endfunction

reg [EBC_W-1:0] near_acc;
reg [EBC_W-1:0] far_acc;
reg [EBC_W-1:0] out_acc;
reg             near_ds_acc;
reg             far_ds_acc;
reg             out_ds_acc;
reg [EBC_W-1:0] near_errored_block_count;
reg [EBC_W-1:0] far_errored_block_count;
reg [EBC_W-1:0] outgoing_far_errored_block_count;
reg             near_defect_second;
reg             far_defect_second;
reg             outgoing_far_defect_second;
reg [`TCM_DEG_M_W-1:0] bad_run;
reg [`TCM_DEG_M_W-1:0] good_run;

wire [EBC_W-1:0] near_now = sat_inc(near_acc, near_errored_block);
wire             bad_sec  = (near_now > deg_thr);

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    near_acc                         <= {EBC_W{1'b0}};
    far_acc                          <= {EBC_W{1'b0}};
    out_acc                          <= {EBC_W{1'b0}};
    near_ds_acc                      <= 1'b0;
    far_ds_acc                       <= 1'b0;
    out_ds_acc                       <= 1'b0;
    near_errored_block_count         <= {EBC_W{1'b0}};
    far_errored_block_count          <= {EBC_W{1'b0}};
    outgoing_far_errored_block_count <= {EBC_W{1'b0}};
    near_defect_second               <= 1'b0;
    far_defect_second                <= 1'b0;
    outgoing_far_defect_second       <= 1'b0;
    pm_update_out                    <= 1'b0;
    bad_run                          <= {`TCM_DEG_M_W{1'b0}};
    good_run                         <= {`TCM_DEG_M_W{1'b0}};
    signal_degrade_defect            <= 1'b0;
  end else begin
    pm_update_out <= one_second_in;
    if (one_second_in) begin
      // Closing second includes this cycle's events
      near_errored_block_count         <= near_now;
      far_errored_block_count          <= sat_inc(far_acc, far_block);
      outgoing_far_errored_block_count <= sat_inc(out_acc, out_block);
      near_defect_second         <= near_ds_acc | trail_signal_fail | equipment_defect_in;
      far_defect_second          <= far_ds_acc | remote_defect;
      outgoing_far_defect_second <= out_ds_acc | outgoing_defect;
      near_acc    <= {EBC_W{1'b0}};
      far_acc     <= {EBC_W{1'b0}};
      out_acc     <= {EBC_W{1'b0}};
      near_ds_acc <= 1'b0;
      far_ds_acc  <= 1'b0;
      out_ds_acc  <= 1'b0;
      if (bad_sec) begin
        good_run <= {`TCM_DEG_M_W{1'b0}};
        if (bad_run != {`TCM_DEG_M_W{1'b1}})
          bad_run <= bad_run + {{(`TCM_DEG_M_W-1){1'b0}}, 1'b1};
        if (bad_run + {{(`TCM_DEG_M_W-1){1'b0}}, 1'b1} >= deg_m)
          signal_degrade_defect <= 1'b1;
      end else begin
        bad_run <= {`TCM_DEG_M_W{1'b0}};
        if (good_run != {`TCM_DEG_M_W{1'b1}})
          good_run <= good_run + {{(`TCM_DEG_M_W-1){1'b0}}, 1'b1};
        if (good_run + {{(`TCM_DEG_M_W-1){1'b0}}, 1'b1} >= deg_m)
          signal_degrade_defect <= 1'b0;
      end
    end else begin
      near_acc    <= near_now;
      far_acc     <= sat_inc(far_acc, far_block);
      out_acc     <= sat_inc(out_acc, out_block);
      near_ds_acc <= near_ds_acc | trail_signal_fail | equipment_defect_in;
      far_ds_acc  <= far_ds_acc | remote_defect;
      out_ds_acc  <= out_ds_acc | outgoing_defect;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// APB read path, zero wait states
// Read data is captured in the setup cycle so it comes from a flop
reg [31:0] rd_mux;
reg        rd_err;

always @* begin
  rd_mux = 32'h0000_0000;
  rd_err = 1'b0;
  case (paddr_in)
    `TCM_CTRL:        rd_mux = {27'h0, ctrl};
    `TCM_DEG_CFG:     rd_mux = {12'h000, deg_m, deg_thr};
    `TCM_DEFECTS:     rd_mux = {23'h0, signal_degrade_defect, trail_signal_fail,
                                outgoing_defect, remote_defect, signal_degrade_defect,
                                trace_mismatch_defect, tc_loss_defect,
                                tc_unequipped_defect, in_mf};
    `TCM_REPORTS:     rd_mux = {25'h0, reports};
    `TCM_PM_DS:       rd_mux = {29'h0, outgoing_far_defect_second,
                                far_defect_second, near_defect_second};
    `TCM_PM_NEAR_EBC: rd_mux = {{(32-EBC_W){1'b0}}, near_errored_block_count};
    `TCM_PM_FAR_EBC:  rd_mux = {{(32-EBC_W){1'b0}}, far_errored_block_count};
    `TCM_PM_OUT_EBC:  rd_mux = {{(32-EBC_W){1'b0}}, outgoing_far_errored_block_count};
    default: begin
      if (paddr_in[7:4] == `TCM_EXP_TI_HI && paddr_in[1:0] == 2'h0)
        rd_mux = exp_ti[{~widx, 5'h1f} -: 32];
      else if (paddr_in[7:4] == `TCM_ACC_TI_HI && paddr_in[1:0] == 2'h0)
        rd_mux = accepted_trace_id[{~widx, 5'h1f} -: 32];
      else
        rd_err = 1'b1;
    end
  endcase
end

assign pready_out = 1'b1;

always @(posedge core_clk_in or negedge rst_sync_n) begin
  if (!rst_sync_n) begin
    prdata_out  <= 32'h0000_0000;
    pslverr_out <= 1'b0;
  end else if (psel_in && !penable_in) begin
    prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
    pslverr_out <= rd_err;
  end
end

endmodule // tandem_connection_monitor_sink

// ==== include/tcm_sink_regs.vh ====
/*
 Register offsets, field positions, reset values and counts of the
 tandem connection monitor sink. Definitions only; included by name.
*/
`ifndef TCM_SINK_REGS_VH
`define TCM_SINK_REGS_VH

// APB byte offsets
`define TCM_CTRL        8'h00
`define TCM_DEG_CFG     8'h04
`define TCM_DEFECTS     8'h08
`define TCM_REPORTS     8'h0c
`define TCM_PM_DS       8'h10
`define TCM_PM_NEAR_EBC 8'h14
`define TCM_PM_FAR_EBC  8'h18
`define TCM_PM_OUT_EBC  8'h1c
`define TCM_EXP_TI_HI   4'h2
`define TCM_ACC_TI_HI   4'h3

// Control fields and reset values
`define TCM_CTRL_MON      0
`define TCM_CTRL_SSF_REP  1
`define TCM_CTRL_RDI_REP  2
`define TCM_CTRL_ODI_REP  3
`define TCM_CTRL_TIM_DIS  4
`define TCM_CTRL_W        5
`define TCM_CTRL_RST      5'h0f
`define TCM_DEG_THR_W     16
`define TCM_DEG_M_LSB     16
`define TCM_DEG_M_W       4
`define TCM_DEG_THR_RST   16'h000a
`define TCM_DEG_M_RST     4'h3

// Multiframe layout of N2 bits 7 and 8, indices from 0
`define TCM_FAS           16'hfffe
`define TCM_MF_LAST       7'h4b
`define TCM_FAS_LAST      7'h07
`define TCM_TTI_FIRST     7'h08
`define TCM_TTI_LAST      7'h47
`define TCM_RDI_IDX       7'h48
`define TCM_ODI_IDX       7'h49

// Unequipped persistence in frames
`define TCM_UNEQ_N        3'h5

`endif

// ==== sim/vc11_source.sv ====
/*
 VC-11 frame source standing upstream of the tandem monitor.
 Assumes one byte a cycle on the bench clock and a short frame.
*/
`timescale 1ns/10ps
module vc11_source #(
  parameter FB = 4
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Fault controls
  input  wire       en_in,
  input  wire       zero_in,
  input  wire       fas_err_in,
  input  wire       bip_err_in,
  input  wire       rdi_in,
  input  wire       odi_in,
  // Byte stream
  output reg  [7:0] byte_out,
  output reg        valid_out,
  output reg        start_out,
  output reg        n2_out
);
  reg [3:0] pos;
  reg [6:0] mf;
  reg [7:0] acc;
  reg [7:0] prv;
  reg [1:0] mfb;
  reg [7:0] b;
  wire [1:0] bip = {prv[7] ^ prv[5] ^ prv[3] ^ prv[1], prv[6] ^ prv[4] ^ prv[2] ^ prv[0]};

  //////////////////////////////////////////////////////////////////////////////
  // Trace bits stay zero; N2 bit 4 set so N2 is never zero by chance
  always @* begin
    mfb = 2'h0;
    if (mf < 7'h7) mfb = 2'h3;
    if (mf == 7'h7) mfb = {1'b1, fas_err_in};
    if (mf == 7'h48) mfb = {1'b0, rdi_in};
    if (mf == 7'h49) mfb = {odi_in, 1'b0};
    b = {pos, mf[3:0]};
    if (pos == 4'h0) b = 8'h00;
    if (pos == 4'h1) b = zero_in ? 8'h00 : {bip ^ {bip_err_in, 1'b0}, 2'h1, {2{bip_err_in}}, mfb};
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos <= 4'h0;
      mf <= 7'h0;
      acc <= 8'h00;
      prv <= 8'h00;
      byte_out <= 8'h00;
      valid_out <= 1'b0;
      start_out <= 1'b0;
      n2_out <= 1'b0;
    end else if (!en_in) begin
      valid_out <= 1'b0;
      start_out <= 1'b0;
      n2_out <= 1'b0;
      // Idle line toggles so stale data is never mistaken for a byte
      byte_out <= ~byte_out;
    end else begin
      valid_out <= 1'b1;
      start_out <= pos == 4'h0;
      n2_out <= pos == 4'h1;
      byte_out <= b;
      acc <= (pos == 4'h0) ? b : acc ^ b;
      if (pos == 4'h0) prv <= acc;
      pos <= (pos == FB - 1) ? 4'h0 : pos + 4'h1;
      if (pos == FB - 1) mf <= (mf == 7'h4b) ? 7'h0 : mf + 7'h1;
    end
  end
endmodule // vc11_source

// ==== sim/tcm_sink_asserts.sv ====
/*
 Port assertions for the tandem monitor.
 Assumes binding into the monitor and stream inputs on its clock.
*/
`timescale 1ns/10ps
module tcm_sink_asserts (
  input wire       core_clk_in,
  input wire       rst_n_in,
  input wire       psel_in,
  input wire       penable_in,
  input wire [7:0] paddr_in,
  input wire       pslverr_out,
  input wire [7:0] vc_byte_in,
  input wire       vc_valid_in,
  input wire       vc_n2_in,
  input wire       incoming_server_fail_in,
  input wire       one_second_in,
  input wire       trail_signal_fail_out,
  input wire       trail_signal_degrade_out,
  input wire       pm_update_out
);
  reg [1:0] up;
  reg [2:0] zc;
  // Reset goes through two flops inside, so wait before judging
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up <= 2'h0;
      zc <= 3'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (vc_valid_in && vc_n2_in) zc <= (vc_byte_in != 8'h00) ? 3'h0 : zc + {2'h0, zc != 3'h5};
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ssf_fail;
    up == 2'h3 && incoming_server_fail_in |-> ##[1:3] trail_signal_fail_out;
  endproperty
  a_ssf_fail: assert property (p_ssf_fail) else $error("server fail without trail fail");
  property p_fail_fall;
    $fell(trail_signal_fail_out) |-> !$past(incoming_server_fail_in);
  endproperty
  a_fail_fall: assert property (p_fail_fall) else $error("trail fail fell under server fail");
  property p_uneq;
    up == 2'h3 && vc_valid_in && vc_n2_in && vc_byte_in == 8'h00 && zc == 3'h4
      |-> ##[1:3] trail_signal_fail_out;
  endproperty
  a_uneq: assert property (p_uneq) else $error("five zero N2 bytes without trail fail");
  property p_pm_pulse;
    up == 2'h3 && one_second_in |=> pm_update_out;
  endproperty
  a_pm_pulse: assert property (p_pm_pulse) else $error("no update after second tick");
  property p_pm_cause;
    pm_update_out |-> $past(one_second_in);
  endproperty
  a_pm_cause: assert property (p_pm_cause) else $error("update without second tick");
  property p_tsd_second;
    up == 2'h3 && $changed(trail_signal_degrade_out)
      |-> $past(one_second_in) || $past(one_second_in, 2) || $past(one_second_in, 3);
  endproperty
  a_tsd_second: assert property (p_tsd_second) else $error("degrade moved off a second");
  property p_bad_addr;
    psel_in && !penable_in && paddr_in[7:6] != 2'h0 |=> pslverr_out;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped address accepted");
  property p_good_addr;
    psel_in && !penable_in && paddr_in[7:6] == 2'h0 && paddr_in[1:0] == 2'h0 |=> !pslverr_out;
  endproperty
  a_good_addr: assert property (p_good_addr) else $error("mapped address refused");
endmodule // tcm_sink_asserts

// ==== sim/tb.sv ====
/*
 Self-checking bench for the tandem monitor with a VC-11 source.
 Assumes a 100 MHz clock and APB registers at the mapped offsets.
*/
`timescale 1ns/10ps
module tb;
  reg         core_clk, rst_n, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdv;
  reg         rde, ssf, eqd, sec, en, zero, ferr, berr, rdi, odi;
  wire [31:0] prdata;
  wire [7:0]  vbyte;
  wire        pready, pslverr, vvalid, vstart, vn2, tsf, tsd, pmu;
  integer     err_total, check_count, i;
  reg  [73:0] rows [0:9];

  always #5 core_clk = ~core_clk;

  tandem_connection_monitor_sink #(.EBC_W(16)) u_tandem_connection_monitor_sink (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .vc_byte_in(vbyte), .vc_valid_in(vvalid),
    .vc_frame_start_in(vstart), .vc_n2_in(vn2), .incoming_server_fail_in(ssf),
    .equipment_defect_in(eqd), .one_second_in(sec), .trail_signal_fail_out(tsf),
    .trail_signal_degrade_out(tsd), .pm_update_out(pmu));

  vc11_source u_vc11_source (
    .clk_in(core_clk), .rst_n_in(rst_n), .en_in(en), .zero_in(zero), .fas_err_in(ferr),
    .bip_err_in(berr), .rdi_in(rdi), .odi_in(odi), .byte_out(vbyte), .valid_out(vvalid),
    .start_out(vstart), .n2_out(vn2));

  //////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          err_total = err_total + 1;
          tally_and_finish;
        end
        @(posedge core_clk);
      end
      rdv = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Settle time lets reports trail the control change
  task wr(input [7:0] a, input [31:0] d);
    begin
      apb(a, 1'b1, d);
      repeat (3) @(posedge core_clk);
    end
  endtask

  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(a, 1'b0, 32'h0);
      chk("rdata", e, rdv & m);
    end
  endtask

  task wait_n2(input integer c);
    integer k;
    repeat (c) begin
      k = 0;
      @(posedge core_clk);
      while (!(vvalid && vn2)) begin
        k = k + 1;
        if (k > 100) begin
          err_total = err_total + 1;
          tally_and_finish;
        end
        @(posedge core_clk);
      end
    end
  endtask

  task tick;
    begin
      sec <= 1'b1;
      @(posedge core_clk);
      sec <= 1'b0;
      @(negedge core_clk);
      chk("pmu", 32'h1, {31'h0, pmu});
      repeat (3) @(posedge core_clk);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Row: address, write, write data, expected read, expected error
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, ssf, eqd, sec, en, zero, ferr, berr, rdi, odi} = 12'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    check_count = 0;
    rows[0] = {8'h00, 1'b0, 32'h0, 32'h0000000f, 1'b0};
    rows[1] = {8'h04, 1'b0, 32'h0, 32'h0003000a, 1'b0};
    rows[2] = {8'h08, 1'b0, 32'h0, 32'h00000084, 1'b0};
    rows[3] = {8'h0c, 1'b0, 32'h0, 32'h00000002, 1'b0};
    rows[4] = {8'h30, 1'b0, 32'h0, 32'h00000000, 1'b0};
    rows[5] = {8'h08, 1'b1, 32'hffffffff, 32'h0, 1'b0};
    rows[6] = {8'h08, 1'b0, 32'h0, 32'h00000084, 1'b0};
    rows[7] = {8'h40, 1'b0, 32'h0, 32'h00000000, 1'b1};
    rows[8] = {8'h04, 1'b1, 32'h00010000, 32'h0, 1'b0};
    rows[9] = {8'h04, 1'b0, 32'h0, 32'h00010000, 1'b0};
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 10; i = i + 1) begin
      apb(rows[i][73:66], rows[i][65], rows[i][64:33]);
      if (!rows[i][65]) chk("rdata", rows[i][32:1], rdv);
      chk("pslverr", {31'h0, rows[i][0]}, {31'h0, rde});
    end
    chk("tsf", 32'h1, {31'h0, tsf});
    en <= 1'b1;
    wait_n2(160);
    rd(8'h08, 32'h1ff, 32'h001);
    chk("tsf", 32'h0, {31'h0, tsf});
    rdi <= 1'b1;
    odi <= 1'b1;
    wait_n2(160);
    rd(8'h08, 32'h1ff, 32'h061);
    rd(8'h0c, 32'h7f, 32'h060);
    wr(8'h00, 32'h0e);
    rd(8'h0c, 32'h7f, 32'h000);
    wr(8'h00, 32'h07);
    rd(8'h0c, 32'h7f, 32'h020);
    wr(8'h00, 32'h0f);
    wr(8'h20, 32'h1);
    wait_n2(100);
    rd(8'h08, 32'h1ff, 32'h0e9);
    rd(8'h0c, 32'h7f, 32'h004);
    wr(8'h00, 32'h1f);
    rd(8'h08, 32'h1ff, 32'h061);
    wr(8'h00, 32'h0f);
    ssf <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(8'h08, 32'h1ff, 32'h0e1);
    rd(8'h0c, 32'h7f, 32'h070);
    wr(8'h00, 32'h0d);
    rd(8'h0c, 32'h7f, 32'h060);
    ssf <= 1'b0;
    wr(8'h20, 32'h0);
    ferr <= 1'b1;
    wait_n2(170);
    rd(8'h08, 32'h1ff, 32'h084);
    rd(8'h0c, 32'h7f, 32'h002);
    ferr <= 1'b0;
    wait_n2(160);
    rd(8'h08, 32'h1ff, 32'h061);
    tick;
    wait_n2(1);
    berr <= 1'b1;
    wait_n2(3);
    berr <= 1'b0;
    wait_n2(2);
    tick;
    rd(8'h14, 32'hffffffff, 32'h3);
    rd(8'h18, 32'hffffffff, 32'h3);
    rd(8'h1c, 32'hffffffff, 32'h3);
    rd(8'h10, 32'h7, 32'h6);
    chk("tsd", 32'h1, {31'h0, tsd});
    rd(8'h08, 32'h110, 32'h110);
    rd(8'h0c, 32'h7f, 32'h068);
    eqd <= 1'b1;
    repeat (4) @(posedge core_clk);
    eqd <= 1'b0;
    tick;
    rd(8'h10, 32'h7, 32'h7);
    chk("tsd", 32'h0, {31'h0, tsd});
    wait_n2(1);
    zero <= 1'b1;
    wait_n2(6);
    rd(8'h08, 32'h82, 32'h82);
    rd(8'h0c, 32'h1, 32'h1);
    zero <= 1'b0;
    wait_n2(6);
    rd(8'h08, 32'h2, 32'h0);
    tally_and_finish;
  end
endmodule // tb

bind tandem_connection_monitor_sink tcm_sink_asserts u_tcm_sink_asserts (.*);
